//--- core/fcr_fault_cause.sv
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - divide by zero sets usage bit 9.
// - unaligned access sets usage bit 8.
// - stack overflow sets usage bit 4.
// - absent or disabled coprocessor sets bit 3.
// - integrity check error sets usage bit 2.
// - bad Thumb or if-then state sets bit 1.
// - undefined instruction sets usage bit 0.
// - usage flags are zero after reset.
// - flags sticky; write one clears, zero keeps.
// - usage flags banked per security state.
// - one hard-fault register shared by both states.
// - ownership zero hides bits 31,30,1 from nonsecure.
// - escalated configurable fault sets forced bit 30.
// - failed vector table read sets bit 1.
// - vector read error always goes to hard fault.
// - vector fault stacks the pre-empted instruction address.
// - combined word accepts byte, halfword or word access.
module fcr_fault_cause #(
    parameter bit SEC_EXT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    // Register bus.
    input wire logic [fcr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [fcr_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [fcr_pkg::BE_W-1:0] avs_byteenable,
    input wire logic avs_nonsecure,
    output logic [fcr_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Usage-fault events from the execution logic.
    input wire logic fault_nonsecure,
    input wire logic zero_divisor_err,
    input wire logic unaligned_err,
    input wire logic stack_overflow_err,
    input wire logic missing_coprocessor_err,
    input wire logic invalid_return_pc_err,
    input wire logic thumb_state_bit_err,
    input wire logic if_then_state_field_err,
    input wire logic undefined_opcode_err,
    // Hard-fault events from the exception logic.
    input wire logic cfg_fault_req,
    input wire logic cfg_fault_enabled,
    input wire logic cfg_fault_can_take,
    input wire logic vector_fetch_err,
    input wire logic debug_event,
    input wire logic [fcr_pkg::DATA_W-1:0] preempted_pc,
    input wire logic [fcr_pkg::DATA_W-1:0] fault_pc,
    // Results for the exception logic.
    output logic hardfault_req,
    output logic [fcr_pkg::DATA_W-1:0] stacked_pc
);
    import fcr_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic hf_req_r;
        logic [DATA_W-1:0] stacked_pc_r;
        logic ns_own_r;
    } fcr_top_s;

    fcr_top_s state_r;
    fcr_top_s state_nxt;

    fcr_reg_if rif ();

    logic [UF_W-1:0] uf_set;
    logic [UF_W-1:0] uf_set_bank [UF_BANKS];
    logic [UF_W-1:0] uf_clr_bank [UF_BANKS];
    logic [UF_W-1:0] uf_flags [UF_BANKS];
    logic [HF_W-1:0] hf_set;
    logic [HF_W-1:0] hf_clr;
    logic [HF_W-1:0] hf_flags;
    logic forced_esc;
    logic evt_bank;
    logic acc_bank;
    logic acc_ns;
    logic hf_hidden;
    logic [UF_W-1:0] uf_wr_mask;
    logic [HF_W-1:0] hf_wr_mask;
    logic [DATA_W-1:0] rdata;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------

    // Handshake and write strobe; byte enables become a bit mask.
    fcr_avalon_slave u_slave (
        .clk_sys(clk_sys),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_nonsecure(avs_nonsecure),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .rif(rif.bus_side)
    );

    // ----------------------------------------------------------------
    // Security view
    // ----------------------------------------------------------------

    // Without the extension every access and event uses the one secure bank.
    assign acc_ns = SEC_EXT & rif.nonsecure;
    assign acc_bank = acc_ns;
    assign evt_bank = SEC_EXT & fault_nonsecure;
    assign hf_hidden = acc_ns & ~state_r.ns_own_r;

    // ----------------------------------------------------------------
    // Usage-fault events
    // ----------------------------------------------------------------

    // Each detected error lands on its own flag position, except the Thumb and if-then state errors, which share bit 1.
    always_comb
    begin
        uf_set = '0;
        uf_set[UF_ZERO_DIV] = zero_divisor_err;
        uf_set[UF_UNALIGNED] = unaligned_err;
        uf_set[UF_STACK_OVF] = stack_overflow_err;
        uf_set[UF_NO_COPROC] = missing_coprocessor_err;
        uf_set[UF_BAD_RET_PC] = invalid_return_pc_err;
        uf_set[UF_BAD_STATE] = thumb_state_bit_err | if_then_state_field_err;
        uf_set[UF_UNDEF_OP] = undefined_opcode_err;
    end

    // Write-one mask on the upper halfword; any byte lane pattern is honoured.
    assign uf_wr_mask = (rif.wr_stb && rif.addr == OFF_COMBINED)
        ? (rif.wdata[UF_LSB +: UF_W] & rif.byte_mask[UF_LSB +: UF_W] & UF_IMPL)
        : '0;

    // One sticky bank per security state; only the accessing state's bank is cleared.
    for (genvar g = 0; g < UF_BANKS; g++)
    begin : g_uf_bank
        assign uf_set_bank[g] = (evt_bank == 1'(g)) ? uf_set : '0;
        assign uf_clr_bank[g] = (acc_bank == 1'(g)) ? uf_wr_mask : '0;
        fcr_sticky_bank #(
            .W(UF_W),
            .RESET_VAL(UF_RESET)
        ) u_uf_bank (
            .clk_sys(clk_sys),
            .reset(reset),
            .set_evt(uf_set_bank[g]),
            .clr_mask(uf_clr_bank[g]),
            .flags(uf_flags[g])
        );
    end

    // ----------------------------------------------------------------
    // Hard-fault events
    // ----------------------------------------------------------------

    // A configurable fault that is disabled or cannot pre-empt escalates.
    assign forced_esc = cfg_fault_req & (~cfg_fault_enabled | ~cfg_fault_can_take);

    // Hard-fault cause flags in their documented positions.
    always_comb
    begin
        hf_set = '0;
        hf_set[HF_DEBUG_EVT] = debug_event;
        hf_set[HF_FORCED] = forced_esc;
        hf_set[HF_VECT_FETCH] = vector_fetch_err;
    end

    // Nonsecure writes are ignored while the hard-fault bits are hidden.
    assign hf_wr_mask = (rif.wr_stb && rif.addr == OFF_HARD && !hf_hidden)
        ? (rif.wdata & rif.byte_mask & HF_IMPL)
        : '0;
    assign hf_clr = hf_wr_mask;

    // A single bank serves both security states.
    fcr_sticky_bank #(
        .W(HF_W),
        .RESET_VAL(HF_RESET)
    ) u_hf_bank (
        .clk_sys(clk_sys),
        .reset(reset),
        .set_evt(hf_set),
        .clr_mask(hf_clr),
        .flags(hf_flags)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------

    // Read mux; unmapped offsets and the lower combined halfword read zero.
    always_comb
    begin
        rdata = RDATA_NONE;
        unique case (rif.addr)
            OFF_COMBINED:
            begin
                rdata[UF_LSB +: UF_W] = uf_flags[acc_bank];
            end
            OFF_HARD:
            begin
                rdata = hf_hidden ? RDATA_NONE : hf_flags;
            end
            OFF_CTRL:
            begin
                rdata[CTRL_NS_OWN] = state_r.ns_own_r;
            end
            default:
            begin
                rdata = RDATA_NONE;
            end
        endcase
    end
    assign rif.rdata = rdata;

    // ----------------------------------------------------------------
    // Control and exception results
    // ----------------------------------------------------------------

    // Ownership is writable from secure state only; a vector read error
    // always requests the hard-fault handler and stacks the pre-empted address.
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.hf_req_r = forced_esc | vector_fetch_err;
        if (vector_fetch_err)
        begin
            state_nxt.stacked_pc_r = preempted_pc;
        end
        else if (forced_esc)
        begin
            state_nxt.stacked_pc_r = fault_pc;
        end
        if (rif.wr_stb && rif.addr == OFF_CTRL && !acc_ns && rif.byte_mask[CTRL_NS_OWN])
        begin
            state_nxt.ns_own_r = rif.wdata[CTRL_NS_OWN];
        end
    end

    // Control state clears at reset.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_r <= '{hf_req_r: 1'b0, stacked_pc_r: PC_RESET, ns_own_r: CTRL_NS_OWN_RESET};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign hardfault_req = state_r.hf_req_r;
    assign stacked_pc = state_r.stacked_pc_r;
endmodule

`default_nettype wire

//--- shared/fcr_pkg.sv
package fcr_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // Byte offsets of the register words.
    localparam logic [ADDR_W-1:0] OFF_COMBINED = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_HARD = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h8;

    // ----------------------------------------------------------------
    // Usage-fault cause layout (16-bit subregister)
    // ----------------------------------------------------------------
    localparam int UF_W = 16;
    localparam int UF_LSB = 16;
    localparam int UF_ZERO_DIV = 9;
    localparam int UF_UNALIGNED = 8;
    localparam int UF_STACK_OVF = 4;
    localparam int UF_NO_COPROC = 3;
    localparam int UF_BAD_RET_PC = 2;
    localparam int UF_BAD_STATE = 1;
    localparam int UF_UNDEF_OP = 0;
    localparam logic [UF_W-1:0] UF_IMPL = 16'h031F;
    localparam logic [UF_W-1:0] UF_RESET = 16'h0000;
    localparam int UF_BANKS = 2;

    // ----------------------------------------------------------------
    // Hard-fault cause layout
    // ----------------------------------------------------------------
    localparam int HF_W = 32;
    localparam int HF_DEBUG_EVT = 31;
    localparam int HF_FORCED = 30;
    localparam int HF_VECT_FETCH = 1;
    localparam logic [HF_W-1:0] HF_IMPL = 32'hC000_0002;
    localparam logic [HF_W-1:0] HF_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Fault control word
    // ----------------------------------------------------------------
    localparam int CTRL_NS_OWN = 0;
    localparam logic CTRL_NS_OWN_RESET = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PC_RESET = 32'h0000_0000;

endpackage

//--- shared/fcr_reg_if.sv
`timescale 1ns/10ps
`default_nettype none

// Register access strobe, write data and read data between bus slave and register file.
interface fcr_reg_if;
    import fcr_pkg::*;

    logic wr_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] byte_mask;
    logic nonsecure;
    logic [DATA_W-1:0] rdata;

    modport bus_side (output wr_stb, output addr, output wdata, output byte_mask,
                      output nonsecure, input rdata);
    modport reg_side (input wr_stb, input addr, input wdata, input byte_mask,
                      input nonsecure, output rdata);
endinterface

`default_nettype wire

//--- core/fcr_sticky_bank.sv
`timescale 1ns/10ps
`default_nettype none

// Sticky flags: events set bits, a clear mask drops them, a set beats a clear.
module fcr_sticky_bank #(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [W-1:0] set_evt,
    input wire logic [W-1:0] clr_mask,
    output logic [W-1:0] flags
);
    import fcr_pkg::*;

    typedef struct packed {
        logic [W-1:0] flags_r;
    } fcr_bank_s;

    fcr_bank_s state_r;
    fcr_bank_s state_nxt;

    // Clear only where a one was written, then apply new events on top.
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.flags_r = (state_r.flags_r & ~clr_mask) | set_evt;
    end

    // Flags hold zero from reset until a fault arrives.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_r <= '{flags_r: RESET_VAL};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign flags = state_r.flags_r;
endmodule

`default_nettype wire

//--- core/fcr_avalon_slave.sv
`timescale 1ns/10ps
`default_nettype none

// Avalon-MM slave with one wait cycle; read data and waitrequest come from flops.
module fcr_avalon_slave (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [fcr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [fcr_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [fcr_pkg::BE_W-1:0] avs_byteenable,
    input wire logic avs_nonsecure,
    output logic [fcr_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    fcr_reg_if.bus_side rif
);
    import fcr_pkg::*;

    typedef struct packed {
        logic wait_r;
        logic [DATA_W-1:0] rdata_r;
    } fcr_slave_s;

    fcr_slave_s state_r;
    fcr_slave_s state_nxt;
    logic [DATA_W-1:0] mask;

    // Expand byte enables into a bit mask.
    always_comb
    begin
        for (int b = 0; b < BE_W; b++)
        begin
            mask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // A write takes effect at the edge where waitrequest is seen low.
    assign rif.wr_stb = avs_write & ~state_r.wait_r;
    assign rif.addr = avs_address;
    assign rif.wdata = avs_writedata;
    assign rif.byte_mask = mask;
    assign rif.nonsecure = avs_nonsecure;

    // First cycle of a request samples read data and drops waitrequest for one cycle.
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.wait_r = 1'b1;
        if ((avs_read | avs_write) & state_r.wait_r)
        begin
            state_nxt.wait_r = 1'b0;
            state_nxt.rdata_r = avs_read ? rif.rdata : RDATA_NONE;
        end
    end

    // Waitrequest stands high while idle.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_r <= '{wait_r: 1'b1, rdata_r: RDATA_NONE};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign avs_readdata = state_r.rdata_r;
    assign avs_waitrequest = state_r.wait_r;
endmodule

`default_nettype wire

//--- bench/fcr_fault_cause_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the fault cause block
// ----------------------------------------------------------------
module fcr_fault_cause_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [fcr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [fcr_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cfg_fault_req,
    input wire logic cfg_fault_enabled,
    input wire logic cfg_fault_can_take,
    input wire logic vector_fetch_err,
    input wire logic [fcr_pkg::DATA_W-1:0] preempted_pc,
    input wire logic [fcr_pkg::DATA_W-1:0] fault_pc,
    input wire logic hardfault_req,
    input wire logic [fcr_pkg::DATA_W-1:0] stacked_pc
);
    import fcr_pkg::*;

    logic forced;
    logic req;

    // Escalation condition and bus request as seen at the pins.
    assign forced = cfg_fault_req && (!cfg_fault_enabled || !cfg_fault_can_take);
    assign req = avs_read || avs_write;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_vect_hard: assert property (vector_fetch_err |=> hardfault_req)
        else $error("vector read error not sent to hard fault");
    a_vect_pc: assert property (vector_fetch_err |=> stacked_pc == $past(preempted_pc))
        else $error("stacked address is not the pre-empted one");
    a_forced_hard: assert property (forced && !vector_fetch_err |=> hardfault_req)
        else $error("escalated fault gave no hard fault");
    a_forced_pc: assert property (forced && !vector_fetch_err
        |=> stacked_pc == $past(fault_pc))
        else $error("stacked address is not the faulting one");
    a_quiet_hard: assert property (!vector_fetch_err && !forced |=> !hardfault_req)
        else $error("hard fault without a cause");
    a_pc_hold: assert property (!vector_fetch_err && !forced |=> $stable(stacked_pc))
        else $error("stacked address moved without a cause");
    a_low_half: assert property (avs_read && avs_waitrequest && avs_address == OFF_COMBINED
        |=> avs_readdata[15:0] == 16'h0000)
        else $error("combined word lower half not zero");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > OFF_CTRL
        |=> avs_readdata == RDATA_NONE)
        else $error("unmapped read not zero");

    c_vect: cover property (vector_fetch_err ##1 hardfault_req);
    c_forced: cover property (forced);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule

bind fcr_fault_cause fcr_fault_cause_chk chk_u (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cfg_fault_req(cfg_fault_req), .cfg_fault_enabled(cfg_fault_enabled),
    .cfg_fault_can_take(cfg_fault_can_take), .vector_fetch_err(vector_fetch_err),
    .preempted_pc(preempted_pc), .fault_pc(fault_pc), .hardfault_req(hardfault_req),
    .stacked_pc(stacked_pc));

`default_nettype wire

//--- bench/fcr_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Execution and exception side that raises fault events
// ----------------------------------------------------------------
module fcr_core_model (
    input wire logic clk_sys,
    output logic [12:0] ev,
    output logic ev_ns,
    output logic [fcr_pkg::DATA_W-1:0] ppc,
    output logic [fcr_pkg::DATA_W-1:0] fpc
);
    import fcr_pkg::*;

    // Quiet lines from time zero.
    initial
    begin
        ev = '0;
        ev_ns = 1'b0;
        ppc = '0;
        fpc = '0;
    end

    // Raises the chosen event lines for one cycle, then shows stale-looking addresses.
    task fire(input logic [12:0] mask, input logic ns, input logic [DATA_W-1:0] pc);
        @(posedge clk_sys);
        ev <= mask;
        ev_ns <= ns;
        ppc <= pc;
        fpc <= pc + 32'h0000_0004;
        @(posedge clk_sys);
        ev <= '0;
        ev_ns <= ~ns;
        ppc <= ~pc;
        fpc <= ~pc;
    endtask
endmodule

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Bench for the fault cause registers
// ----------------------------------------------------------------
module tb_top;
    import fcr_pkg::*;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [BE_W-1:0] avs_byteenable = '0;
    logic avs_nonsecure = 1'b0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [12:0] ev;
    logic ev_ns;
    logic [DATA_W-1:0] ppc;
    logic [DATA_W-1:0] fpc;
    logic hf_req;
    logic [DATA_W-1:0] spc;
    logic [DATA_W-1:0] q;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int ubit[8] = '{0, 1, 1, 2, 3, 4, 8, 9};

    fcr_core_model core_u (.clk_sys(clk_sys), .ev(ev), .ev_ns(ev_ns), .ppc(ppc), .fpc(fpc));

    fcr_fault_cause dut_u (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_nonsecure(avs_nonsecure),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fault_nonsecure(ev_ns), .zero_divisor_err(ev[7]), .unaligned_err(ev[6]),
        .stack_overflow_err(ev[5]), .missing_coprocessor_err(ev[4]),
        .invalid_return_pc_err(ev[3]), .thumb_state_bit_err(ev[2]),
        .if_then_state_field_err(ev[1]), .undefined_opcode_err(ev[0]),
        .cfg_fault_req(ev[8]), .cfg_fault_enabled(ev[9]), .cfg_fault_can_take(ev[10]),
        .vector_fetch_err(ev[11]), .debug_event(ev[12]), .preempted_pc(ppc),
        .fault_pc(fpc), .hardfault_req(hf_req), .stacked_pc(spc));

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    // Prints the counts and the verdict, then stops.
    task end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    // Compares one seen value against its expectation.
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One bus cycle, held until waitrequest is sampled low.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
             input logic ns);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_nonsecure <= ns;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic ns, input string name, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hF, ns);
        chk(name, q, exp);
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be, input logic ns);
        bus(1'b1, a, d, be, ns);
    endtask

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rd(OFF_COMBINED, 1'b0, "usage secure", 32'h0000_0000);
        rd(OFF_COMBINED, 1'b1, "usage nonsecure", 32'h0000_0000);
        rd(OFF_HARD, 1'b0, "hard", 32'h0000_0000);
        for (int i = 0; i < 8; i++)
        begin
            core_u.fire(13'h0001 << i, 1'b0, 32'h0000_0000);
            rd(OFF_COMBINED, 1'b0, "set", 32'h0001_0000 << ubit[i]);
            wr(OFF_COMBINED, 32'h0000_0000, 4'hF, 1'b0);
            rd(OFF_COMBINED, 1'b1, "other bank", 32'h0000_0000);
            rd(OFF_COMBINED, 1'b0, "zero kept", 32'h0001_0000 << ubit[i]);
            wr(OFF_COMBINED, 32'hFFFF_0000, 4'hC, 1'b0);
            rd(OFF_COMBINED, 1'b0, "cleared", 32'h0000_0000);
        end
        core_u.fire(13'h0081, 1'b0, 32'h0000_0000);
        wr(OFF_COMBINED, 32'hFFFF_FFFF, 4'h4, 1'b0);
        rd(OFF_COMBINED, 1'b0, "lane 2", 32'h0200_0000);
        wr(OFF_COMBINED, 32'hFFFF_FFFF, 4'h8, 1'b0);
        rd(OFF_COMBINED, 1'b0, "lane 3", 32'h0000_0000);
        core_u.fire(13'h0080, 1'b1, 32'h0000_0000);
        rd(OFF_COMBINED, 1'b1, "ns bank", 32'h0200_0000);
        rd(OFF_COMBINED, 1'b0, "s bank", 32'h0000_0000);
        wr(OFF_COMBINED, 32'h0200_0000, 4'hC, 1'b1);
        rd(OFF_COMBINED, 1'b1, "ns cleared", 32'h0000_0000);
        core_u.fire(13'h0700, 1'b0, 32'h0000_0000);
        rd(OFF_HARD, 1'b0, "taken fault", 32'h0000_0000);
        core_u.fire(13'h0500, 1'b0, 32'h0000_0000);
        core_u.fire(13'h0300, 1'b0, 32'h0000_0000);
        core_u.fire(13'h0800, 1'b0, 32'h0000_1234);
        // The request and the stacked address launched at the event edge are seen at the next.
        @(posedge clk_sys);
        chk("hard request", 32'(hf_req), 32'h0000_0001);
        chk("stacked pc", spc, 32'h0000_1234);
        core_u.fire(13'h1000, 1'b0, 32'h0000_0000);
        rd(OFF_HARD, 1'b0, "hard set", 32'hC000_0002);
        rd(OFF_COMBINED, 1'b0, "other causes", 32'h0000_0000);
        rd(OFF_HARD, 1'b1, "ns hidden", 32'h0000_0000);
        wr(OFF_HARD, 32'hFFFF_FFFF, 4'hF, 1'b1);
        rd(OFF_HARD, 1'b0, "ns ignored", 32'hC000_0002);
        wr(OFF_CTRL, 32'h0000_0001, 4'hF, 1'b0);
        rd(OFF_HARD, 1'b1, "shared", 32'hC000_0002);
        wr(OFF_HARD, 32'hC000_0000, 4'hF, 1'b1);
        rd(OFF_HARD, 1'b0, "ns clear", 32'h0000_0002);
        wr(OFF_HARD, 32'h8000_0002, 4'hF, 1'b0);
        rd(OFF_HARD, 1'b0, "hard cleared", 32'h0000_0000);
        wr(4'hC, 32'hFFFF_FFFF, 4'hF, 1'b0);
        rd(4'hC, 1'b0, "unmapped", 32'h0000_0000);
        end_of_test();
    end
endmodule

`default_nettype wire
